/* rtl/sbs_pkg.sv */
/*
 package of the burst memory control block: widths, burst order, snooze latency.
 assumes one 50 MHz clock and no software-visible registers.
*/
package sbs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned ADDR_W = 19;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LANES = 4;
	localparam int unsigned LANE_W = 8;
	// snooze entry and exit latency, in clock periods
	localparam int unsigned SNOOZE_ENTER_PERIODS = 2;
	localparam int unsigned SNOOZE_EXIT_PERIODS = 2;
	localparam int unsigned SNOOZE_ENTER_CYC = (SNOOZE_ENTER_PERIODS * CLK_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int unsigned SNOOZE_EXIT_CYC = (SNOOZE_EXIT_PERIODS * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] BURST_STEP = 2'h1;
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
	localparam int unsigned FIFO_DEPTH = 16;
	typedef enum logic [1:0] {SBS_IDLE, SBS_ACTIVE, SBS_SNOOZE} sbs_state_e;
endpackage

/* rtl/sbs_fifo.sv */
/*
 small synchronous fifo with valid/ready on both sides; read data come from a register.
 assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module sbs_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic [WIDTH-1:0] dat_q, dat_d;
	logic vld_q, vld_d;
	logic push, pop, empty;
	////////////////////////////////////////////////////////////////
	// pointer and output stage next values
	always_comb
	begin
		empty = (wr_q == rd_q);
		in_ready_o = !((wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]));
		push = in_valid_i && in_ready_o;
		pop = !empty && (!vld_q || out_ready_i);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		dat_d = pop ? mem_q[rd_q[AW-1:0]] : dat_q;
		vld_d = pop ? 1'b1 : (out_ready_i ? 1'b0 : vld_q);
	end
	// storage has no reset
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			dat_q <= '0;
			vld_q <= 1'b0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			dat_q <= dat_d;
			vld_q <= vld_d;
		end
	end
	assign out_valid_o = vld_q;
	assign out_data_o = dat_q;
endmodule

/* rtl/sbs_ctrl.sv */
/*
 control logic of a synchronous burst memory, seen from the memory side.
 decodes strobe, chip select and lane writes into cycles, steps bursts, sequences
 output enable and snooze. accesses leave as a command stream through a 16-word fifo
 to the array logic, which returns read data on a plain strobe.
 assumes the controller keeps its own obligations on setup, stability and snooze use.
*/
`timescale 1ns/1ps
module sbs_ctrl
	import sbs_pkg::*;
#(
	parameter int unsigned FIFO_D = FIFO_DEPTH
)
(
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic CHIP_SELECT_N_I,
	input wire logic ADDR_STROBE_N_I,
	input wire logic BYTE_WRITE_GATE_N_I,
	input wire logic [LANES-1:0] LANE_WRITE_N_I,
	input wire logic OUTPUT_ENABLE_N_I,
	input wire logic SNOOZE_REQUEST_I,
	input wire logic BURST_ORDER_I,
	input wire logic [DATA_W-1:0] DQ_I,
	output logic [DATA_W-1:0] DQ_O,
	output logic DQ_OE_O,
	output logic SNOOZE_O,
	output logic CMD_VALID_O,
	input wire logic CMD_READY_I,
	output logic CMD_WRITE_O,
	output logic [LANES-1:0] CMD_LANES_O,
	output logic [ADDR_W-1:0] CMD_ADDR_O,
	output logic [DATA_W-1:0] CMD_DATA_O,
	input wire logic RD_VALID_I,
	input wire logic [DATA_W-1:0] RD_DATA_I,
	output logic CMD_STALL_O
);
	localparam int unsigned CMD_W = 1 + LANES + ADDR_W + DATA_W;
	// async pins: snooze request and output enable pass two flip-flops
	logic snz_m_q, snz_s_q, oe_m_q, oe_s_q;
	logic [1:0] snz_cnt_q, snz_cnt_d;
	sbs_state_e st_q, st_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [1:0] beat_q, beat_d;
	logic sel_q, sel_d;
	logic rd_pend_q, rd_pend_d;
	logic [DATA_W-1:0] dq_q, dq_d;
	logic drive_q, drive_d;
	logic snooze_q, snooze_d;
	logic stall_q, stall_d;
	logic is_write, is_read, active, fifo_ready;
	logic [LANES-1:0] wr_lanes;
	logic [1:0] low_bits;
	logic [ADDR_W-1:0] cur_addr;
	logic [CMD_W-1:0] cmd_word;
	////////////////////////////////////////////////////////////////
	// synchronisers for the asynchronous pins
	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			snz_m_q <= 1'b0;
			snz_s_q <= 1'b0;
			oe_m_q <= 1'b1;
			oe_s_q <= 1'b1;
		end
		else
		begin
			snz_m_q <= SNOOZE_REQUEST_I;
			snz_s_q <= snz_m_q;
			oe_m_q <= OUTPUT_ENABLE_N_I;
			oe_s_q <= oe_m_q;
		end
	end
	////////////////////////////////////////////////////////////////
	// cycle decode and burst address
	always_comb
	begin
		// lane written only while the gate is low
		wr_lanes = BYTE_WRITE_GATE_N_I ? '0 : ~LANE_WRITE_N_I;
		active = (st_q != SBS_SNOOZE) && !snz_s_q;
		is_write = active && (wr_lanes != '0) && (!ADDR_STROBE_N_I ? !CHIP_SELECT_N_I : sel_q);
		is_read = active && (wr_lanes == '0) && (!ADDR_STROBE_N_I ? !CHIP_SELECT_N_I : sel_q);
		// burst order: interleaved xor, or linear add with wrap
		if (BURST_ORDER_I)
			low_bits = base_q[1:0] ^ beat_q;
		else
			low_bits = base_q[1:0] + beat_q;
		cur_addr = !ADDR_STROBE_N_I ? ADDR_I : {base_q[ADDR_W-1:2], low_bits};
	end
	////////////////////////////////////////////////////////////////
	// control state next values
	always_comb
	begin
		st_d = st_q;
		snz_cnt_d = snz_cnt_q;
		base_d = base_q;
		beat_d = beat_q;
		sel_d = sel_q;
		rd_pend_d = 1'b0;
		snooze_d = snooze_q;
		stall_d = !fifo_ready;
		case (st_q)
			SBS_IDLE, SBS_ACTIVE:
			begin
				if (snz_s_q)
				begin
					st_d = SBS_SNOOZE;
					snooze_d = 1'b1;
					sel_d = 1'b0;
				end
				else if (!ADDR_STROBE_N_I)
				begin
					// new address aborts any burst
					base_d = ADDR_I;
					beat_d = '0;
					sel_d = !CHIP_SELECT_N_I;
					st_d = CHIP_SELECT_N_I ? SBS_IDLE : SBS_ACTIVE;
					rd_pend_d = is_read;
				end
				else
				begin
					// strobe high: repeat at current internal address
					rd_pend_d = is_read;
				end
			end
			SBS_SNOOZE:
			begin
				if (!snz_s_q)
				begin
					// exit latency before sampling resumes
					if (snz_cnt_q == 2'(SNOOZE_EXIT_CYC - 1))
					begin
						st_d = SBS_IDLE;
						snz_cnt_d = '0;
					end
					else
						snz_cnt_d = snz_cnt_q + 1'b1;
					snooze_d = 1'b0;
				end
				else
				begin
					snz_cnt_d = '0;
					snooze_d = 1'b1;
				end
			end
			default:
				st_d = SBS_IDLE;
		endcase
		// each strobe-high access moves the burst one beat on
		if (ADDR_STROBE_N_I && (is_read || is_write))
			beat_d = beat_q + BURST_STEP;
		// read data are driven only after the edge that took the read
		dq_d = RD_VALID_I ? RD_DATA_I : dq_q;
		drive_d = sel_q && (rd_pend_q || drive_q) && !oe_s_q && st_q != SBS_SNOOZE && !snz_s_q;
		if (is_write || (LANE_WRITE_N_I != LANES_IDLE && active))
			drive_d = 1'b0;
		if (!ADDR_STROBE_N_I && CHIP_SELECT_N_I)
			drive_d = 1'b0;
	end
	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			st_q <= SBS_IDLE;
			snz_cnt_q <= '0;
			base_q <= '0;
			beat_q <= '0;
			sel_q <= 1'b0;
			rd_pend_q <= 1'b0;
			dq_q <= '0;
			drive_q <= 1'b0;
			snooze_q <= 1'b0;
			stall_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			snz_cnt_q <= snz_cnt_d;
			base_q <= base_d;
			beat_q <= beat_d;
			sel_q <= sel_d;
			rd_pend_q <= rd_pend_d;
			dq_q <= dq_d;
			drive_q <= drive_d;
			snooze_q <= snooze_d;
			stall_q <= stall_d;
		end
	end
	////////////////////////////////////////////////////////////////
	// command stream to the array through the fifo
	assign cmd_word = {is_write, wr_lanes, cur_addr, DQ_I};
	sbs_fifo #(
		.WIDTH(CMD_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.clk_i(CLOCK_I),
		.rst_b_i(RST_B_I),
		.in_valid_i(is_write || is_read),
		.in_ready_o(fifo_ready),
		.in_data_i(cmd_word),
		.out_valid_o(CMD_VALID_O),
		.out_ready_i(CMD_READY_I),
		.out_data_o({CMD_WRITE_O, CMD_LANES_O, CMD_ADDR_O, CMD_DATA_O})
	);
	assign DQ_O = dq_q;
	assign DQ_OE_O = drive_q;
	assign SNOOZE_O = snooze_q;
	assign CMD_STALL_O = stall_q;
endmodule

/* testbench/sbs_ctrl_checker.sv */
/*
 port checker of the burst memory control block.
 assumes one clock and a bind to sbs_ctrl.
*/
`timescale 1ns/1ps
module sbs_ctrl_checker
	import sbs_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic CHIP_SELECT_N_I,
	input wire logic ADDR_STROBE_N_I,
	input wire logic BYTE_WRITE_GATE_N_I,
	input wire logic [LANES-1:0] LANE_WRITE_N_I,
	input wire logic SNOOZE_REQUEST_I,
	input wire logic DQ_OE_O,
	input wire logic SNOOZE_O,
	input wire logic CMD_VALID_O,
	input wire logic CMD_WRITE_O,
	input wire logic [ADDR_W-1:0] CMD_ADDR_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////////////////////////
	// long awake, one deselect, then an access into an empty fifo
	sequence s_go;
		(!SNOOZE_REQUEST_I && !SNOOZE_O)[*6] ##0 (!ADDR_STROBE_N_I && CHIP_SELECT_N_I)
		##1 (!ADDR_STROBE_N_I && !CHIP_SELECT_N_I && !SNOOZE_REQUEST_I && !CMD_VALID_O);
	endsequence
	property p_read;
		s_go ##0 (LANE_WRITE_N_I == LANES_IDLE) |-> ##2 (CMD_VALID_O && !CMD_WRITE_O && CMD_ADDR_O == $past(ADDR_I, 2));
	endproperty
	property p_write;
		s_go ##0 (!BYTE_WRITE_GATE_N_I && LANE_WRITE_N_I != LANES_IDLE) |-> ##1 !DQ_OE_O ##1 (CMD_VALID_O && CMD_WRITE_O);
	endproperty
	property p_gate;
		s_go ##0 BYTE_WRITE_GATE_N_I |-> ##2 (CMD_VALID_O && !CMD_WRITE_O);
	endproperty
	property p_enter;
		$rose(SNOOZE_REQUEST_I) |-> ##[1:3] SNOOZE_O;
	endproperty
	property p_exit;
		$fell(SNOOZE_REQUEST_I) |-> ##[1:4] !SNOOZE_O;
	endproperty
	property p_awake;
		(!SNOOZE_REQUEST_I)[*4] |-> !SNOOZE_O;
	endproperty
	property p_quiet;
		SNOOZE_O |-> !DQ_OE_O;
	endproperty
	property p_ignore;
		SNOOZE_O[*3] ##0 !CMD_VALID_O |=> !CMD_VALID_O;
	endproperty
	a_read: assert property (p_read) else $error("read not queued");
	a_write: assert property (p_write) else $error("write not queued");
	a_gate: assert property (p_gate) else $error("closed gate not a read");
	a_enter: assert property (p_enter) else $error("snooze late");
	a_exit: assert property (p_exit) else $error("snooze exit late");
	a_awake: assert property (p_awake) else $error("snooze without request");
	a_quiet: assert property (p_quiet) else $error("data driven in snooze");
	a_ignore: assert property (p_ignore) else $error("access taken in snooze");
endmodule
bind sbs_ctrl sbs_ctrl_checker i_chk (.*);

/* testbench/sbs_array_model.sv */
/*
 array side model: takes commands, answers reads a cycle later, logs commands.
 assumes commands arrive packed with unused fields zeroed.
*/
`timescale 1ns/1ps
module sbs_array_model
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hold_i,
	input wire logic valid_i,
	output logic ready_o,
	input wire logic [55:0] cmd_i,
	output logic rd_valid_o,
	output logic [31:0] rd_data_o
);
	logic [55:0] log_q[$];
	assign ready_o = !hold_i;
	// read data outside the strobe toggle so stale data never matches
	always @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			rd_valid_o <= 1'b0;
		else
		begin
			rd_valid_o <= valid_i && ready_o && !cmd_i[55];
			rd_data_o <= (valid_i && ready_o && !cmd_i[55]) ? {13'h0, cmd_i[50:32]} : ~rd_data_o;
			if (valid_i && ready_o)
				log_q.push_back(cmd_i);
		end
endmodule

/* testbench/tb_top.sv */
/*
 testbench of the burst memory control block: drives the memory pins.
 assumes the array model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
	import sbs_pkg::*;
;
	logic clk = 0, rst_b = 0, cs_n = 1, as_n = 1, gate_n = 1, oe_n = 0, snz = 0, order = 0, hold = 0;
	logic [3:0] lanes_n = 4'hf, cmd_l;
	logic [ADDR_W-1:0] addr = '0, cmd_a;
	logic [31:0] dq = '0, dq_o, rd_data, cmd_d;
	logic dq_oe, snz_o, cmd_v, cmd_r, cmd_w, rd_v, stall;
	int mismatches = 0, n_compared = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	sbs_ctrl i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .CHIP_SELECT_N_I(cs_n), .ADDR_STROBE_N_I(as_n),
		.BYTE_WRITE_GATE_N_I(gate_n), .LANE_WRITE_N_I(lanes_n), .OUTPUT_ENABLE_N_I(oe_n), .SNOOZE_REQUEST_I(snz),
		.BURST_ORDER_I(order), .DQ_I(dq), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .SNOOZE_O(snz_o), .CMD_VALID_O(cmd_v),
		.CMD_READY_I(cmd_r), .CMD_WRITE_O(cmd_w), .CMD_LANES_O(cmd_l), .CMD_ADDR_O(cmd_a), .CMD_DATA_O(cmd_d),
		.RD_VALID_I(rd_v), .RD_DATA_I(rd_data), .CMD_STALL_O(stall));
	sbs_array_model u_arr (.clk_i(clk), .rst_b_i(rst_b), .hold_i(hold), .valid_i(cmd_v), .ready_o(cmd_r),
		.cmd_i({cmd_w, cmd_w ? cmd_l : 4'h0, cmd_a, cmd_w ? cmd_d : 32'h0}), .rd_valid_o(rd_v), .rd_data_o(rd_data));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string what, logic [55:0] exp, logic [55:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one bus cycle held across one rising edge
	task automatic cyc(logic s, logic c, logic g, logic [3:0] l, logic [ADDR_W-1:0] a);
		as_n = s;
		cs_n = c;
		gate_n = g;
		lanes_n = l;
		addr = a;
		dq = {a[12:0], a};
		@(posedge clk);
		#1;
	endtask
	task automatic take(string what, logic [55:0] exp);
		int n = 0;
		while (u_arr.log_q.size() == 0 && n < 60)
		begin
			cyc(0, 1, 1, 4'hf, '0);
			n++;
		end
		if (n == 60)
		begin
			mismatches++;
			close_out();
		end
		else
			chk(what, exp, u_arr.log_q.pop_front());
	endtask
	task automatic restart(logic o);
		rst_b = 0;
		order = o;
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// read, full word write, one lane, closed gate
	task automatic t_access();
		logic [3:0] ln[4] = '{4'hf, 4'h0, 4'he, 4'h0};
		logic gt[4] = '{1, 0, 0, 1};
		for (int i = 0; i < 4; i++)
		begin
			logic [ADDR_W-1:0] a = 19'h01230 + 19'(i);
			logic w = !gt[i] && ln[i] != 4'hf;
			// output enable held high well around every write, also one after a read
			oe_n = w;
			cyc(0, 1, 1, 4'hf, '0);
			cyc(0, 0, gt[i], ln[i], a);
			take("command", {w, w ? ~ln[i] : 4'h0, a, w ? {a[12:0], a} : 32'h0});
			repeat (3) cyc(0, 1, 1, 4'hf, '0);
			if (!w)
				chk("read data", {13'h0, a}, dq_o);
		end
	endtask
	// burst from an odd start, strobe high steps the low bits
	task automatic t_burst();
		logic [ADDR_W-1:0] b = 19'h00a41;
		cyc(0, 1, 1, 4'hf, '0);
		cyc(0, 0, 1, 4'hf, b);
		chk("early drive", 0, dq_oe);
		repeat (4) cyc(1, 1, 1, 4'hf, '0);
		chk("read drive", 1, dq_oe);
		// first strobe-high access repeats the loaded address, later ones step and wrap
		for (int i = 0; i < 5; i++)
		begin
			logic [1:0] k = 2'(i - (i != 0));
			take("burst", {5'h0, b[18:2], order ? b[1:0] ^ k : b[1:0] + k, 32'h0});
		end
	endtask
	// accesses inside snooze are dropped
	task automatic t_snooze();
		snz = 1;
		repeat (4) cyc(0, 1, 1, 4'hf, '0);
		chk("snooze", 1, snz_o);
		repeat (3) cyc(0, 0, 0, 4'h0, 19'h00077);
		snz = 0;
		repeat (6) cyc(0, 1, 1, 4'hf, '0);
		chk("awake", 0, snz_o);
		chk("dropped", 0, u_arr.log_q.size());
	endtask
	// stalled far side fills the fifo until refused, then drains
	task automatic t_fill();
		logic seen = 0;
		hold = 1;
		cyc(0, 0, 1, 4'hf, 19'h00100);
		repeat (20)
		begin
			cyc(1, 1, 1, 4'hf, '0);
			seen |= stall;
		end
		hold = 0;
		repeat (30) cyc(0, 1, 1, 4'hf, '0);
		chk("stall", 1, seen);
		chk("drained", 0, cmd_v);
		chk("stall low", 0, stall);
		u_arr.log_q.delete();
	endtask
	initial
	begin
		restart(0);
		t_access();
		t_burst();
		t_snooze();
		t_fill();
		restart(1);
		t_burst();
		close_out();
	end
endmodule
